// >>> hw/rtc_serial_clock.sv
`timescale 1ns/100ps
`default_nettype none
`include "rtc_cfg.svh"

// Behaviour
// - Slave only; answers only addresses D0h and D1h (68h plus direction bit) after START.
// - Eight byte registers in order seconds to control.
// - Pointer increments after each data byte, written or read.
// - Clock and calendar fields are packed BCD, tens and units.
// - Seconds advance from the 32.768 kHz crystal time base.
// - Supply fail aborts any access and clears the pointer.
// - During supply fail bus inputs are ignored, no writes taken.
// - Register 0: halt bit 7, tens 6:4, units 3:0, 00-59.
// - Century flag toggles at century rollover only when enabled.
// - Register 7: output level, test enable, sign, five-bit calibration.
// - Time registers readable singly or as a burst.
// - Data changes only while clock low; otherwise a control condition.
// - Data falling while clock high is START.
// - Data rising while clock high is STOP, bus idle.
// - One clock pulse per bit, sampled while clock high.
// - No limit on bytes between START and STOP.
// - Eight-bit bytes, each followed by receiver acknowledge.
// - Works at serial clock rates from 2 kHz to 100 kHz.
// - Device acknowledges each received byte; master acks all but last.
// - Master nack ends read; device releases data line.
module rtc_serial_clock (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Serial bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // Crystal time base and supply monitor
    input wire logic crystal_input,
    input wire logic supply_fail_i,
    // Level output; the frequency test output is not produced
    output logic test_or_level_output_pin
);

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers

    logic [1:0] scl_sync_ff, sda_sync_ff, xtal_sync_ff, fail_sync_ff;
    logic scl_ff, sda_ff, xtal_ff;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            scl_sync_ff <= 2'b11;
            sda_sync_ff <= 2'b11;
            xtal_sync_ff <= 2'b00;
            fail_sync_ff <= 2'b00;
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
            xtal_ff <= 1'b0;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_i};
            sda_sync_ff <= {sda_sync_ff[0], sda_i};
            xtal_sync_ff <= {xtal_sync_ff[0], crystal_input};
            fail_sync_ff <= {fail_sync_ff[0], supply_fail_i};
            scl_ff <= scl_sync_ff[1];
            sda_ff <= sda_sync_ff[1];
            xtal_ff <= xtal_sync_ff[1];
        end
    end

    wire logic fail = fail_sync_ff[1];
    // While failing, the lines are seen as idle high so nothing is decoded
    wire logic scl_now = fail ? 1'b1 : scl_sync_ff[1];
    wire logic sda_now = fail ? 1'b1 : sda_sync_ff[1];
    wire logic scl_old = fail ? 1'b1 : scl_ff;
    wire logic sda_old = fail ? 1'b1 : sda_ff;
    rtc_pkg::bus_event_t ev;
    // One driver for the whole event word
    assign ev = '{
        start: scl_now && scl_old && sda_old && !sda_now,
        stop: scl_now && scl_old && !sda_old && sda_now,
        scl_rise: scl_now && !scl_old,
        scl_fall: !scl_now && scl_old,
        sda: sda_now
    };

    ////////////////////////////////////////////////////////////////////////////
    // Time base: one tick per 32768 crystal rising edges

    logic [`CRYSTAL_DIV_W-1:0] xdiv_ff;
    wire logic xtal_rise = xtal_sync_ff[1] && !xtal_ff;
    wire logic tick = xtal_rise && (xdiv_ff == {`CRYSTAL_DIV_W{1'b1}});

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            xdiv_ff <= '0;
        end else if (xtal_rise) begin
            xdiv_ff <= xdiv_ff + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave

    rtc_pkg::bus_state_t state_ff, nxt_state;
    logic [7:0] shift_ff, nxt_shift;
    logic [3:0] bit_ff, nxt_bit;
    logic [2:0] ptr_ff, nxt_ptr;
    logic first_ff, nxt_first;
    logic rd_dir_ff, nxt_rd_dir;
    logic nack_ff, nxt_nack;
    logic sda_ff_o, nxt_sda_o;
    rtc_pkg::reg_write_t wr;
    logic [7:0] rd_data;
    logic [7:0] control;

    wire logic [7:0] rx_byte = {shift_ff[6:0], ev.sda};
    wire logic [2:0] ptr_inc = ptr_ff + 3'h1;

    always_comb begin
        nxt_state = state_ff;
        nxt_shift = shift_ff;
        nxt_bit = bit_ff;
        nxt_ptr = ptr_ff;
        nxt_first = first_ff;
        nxt_rd_dir = rd_dir_ff;
        nxt_nack = nack_ff;
        nxt_sda_o = sda_ff_o;
        wr = '0;
        case (state_ff)
            rtc_pkg::ST_IDLE: begin
                nxt_sda_o = 1'b1;
            end
            rtc_pkg::ST_ADDR, rtc_pkg::ST_WRITE: begin
                if (ev.scl_rise) begin
                    nxt_shift = rx_byte;
                    nxt_bit = bit_ff + 4'h1;
                end
                if (ev.scl_fall && bit_ff == 4'h8) begin
                    nxt_bit = 4'h0;
                    if (state_ff == rtc_pkg::ST_ADDR) begin
                        if (shift_ff[7:1] == `SLAVE_ADDRESS) begin
                            nxt_rd_dir = shift_ff[0];
                            nxt_first = 1'b1;
                            nxt_sda_o = 1'b0;
                            nxt_state = rtc_pkg::ST_ADDR_ACK;
                        end else begin
                            nxt_state = rtc_pkg::ST_IDLE;
                        end
                    end else begin
                        if (first_ff) begin
                            nxt_ptr = shift_ff[2:0];
                            nxt_first = 1'b0;
                        end else begin
                            wr.en = 1'b1;
                            wr.addr = ptr_ff;
                            wr.data = shift_ff;
                            nxt_ptr = ptr_inc;
                        end
                        nxt_sda_o = 1'b0;
                        nxt_state = rtc_pkg::ST_WRITE_ACK;
                    end
                end
            end
            rtc_pkg::ST_ADDR_ACK, rtc_pkg::ST_WRITE_ACK: begin
                if (ev.scl_fall) begin
                    if (rd_dir_ff && state_ff == rtc_pkg::ST_ADDR_ACK) begin
                        nxt_shift = {rd_data[6:0], 1'b0};
                        nxt_sda_o = rd_data[7];
                        nxt_bit = 4'h1;
                        nxt_state = rtc_pkg::ST_READ;
                    end else begin
                        nxt_sda_o = 1'b1;
                        nxt_state = rtc_pkg::ST_WRITE;
                    end
                end
            end
            rtc_pkg::ST_READ: begin
                if (ev.scl_fall) begin
                    if (bit_ff == 4'h8) begin
                        nxt_sda_o = 1'b1;
                        nxt_ptr = ptr_inc;
                        nxt_state = rtc_pkg::ST_READ_ACK;
                    end else begin
                        nxt_sda_o = shift_ff[7];
                        nxt_shift = {shift_ff[6:0], 1'b0};
                        nxt_bit = bit_ff + 4'h1;
                    end
                end
            end
            rtc_pkg::ST_READ_ACK: begin
                if (ev.scl_rise) begin
                    nxt_nack = ev.sda;
                end
                if (ev.scl_fall) begin
                    if (nack_ff) begin
                        nxt_sda_o = 1'b1;
                        nxt_state = rtc_pkg::ST_IDLE;
                    end else begin
                        nxt_shift = {rd_data[6:0], 1'b0};
                        nxt_sda_o = rd_data[7];
                        nxt_bit = 4'h1;
                        nxt_state = rtc_pkg::ST_READ;
                    end
                end
            end
            default: begin
                nxt_state = rtc_pkg::ST_IDLE;
            end
        endcase
        if (ev.start) begin
            nxt_state = rtc_pkg::ST_ADDR;
            nxt_bit = 4'h0;
            nxt_sda_o = 1'b1;
        end
        if (ev.stop) begin
            nxt_state = rtc_pkg::ST_IDLE;
            nxt_sda_o = 1'b1;
        end
        if (fail) begin
            nxt_state = rtc_pkg::ST_IDLE;
            nxt_ptr = 3'h0;
            nxt_sda_o = 1'b1;
            wr.en = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_ff <= rtc_pkg::ST_IDLE;
            shift_ff <= 8'h00;
            bit_ff <= 4'h0;
            ptr_ff <= 3'h0;
            first_ff <= 1'b0;
            rd_dir_ff <= 1'b0;
            nack_ff <= 1'b0;
            sda_ff_o <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            shift_ff <= nxt_shift;
            bit_ff <= nxt_bit;
            ptr_ff <= nxt_ptr;
            first_ff <= nxt_first;
            rd_dir_ff <= nxt_rd_dir;
            nack_ff <= nxt_nack;
            sda_ff_o <= nxt_sda_o;
        end
    end

    // Open drain: drive low only, enable active low while pulling
    assign sda_o = 1'b0;
    assign sda_oe_n_o = sda_ff_o;

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    rtc_regfile u_regs (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .wr_i(wr),
        .rd_addr_i(ptr_ff),
        .rd_data_o(rd_data),
        .tick_i(tick),
        .control_o(control)
    );

    // Frequency test output is out of scope; the level bit drives the pin
    assign test_or_level_output_pin = control[`OUT_LEVEL_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    AST_FAIL_PTR: assert property (@(posedge clk_i) disable iff (reset_i)
        fail |=> ptr_ff == 3'h0) else $error("pointer not cleared on supply fail");
    AST_FAIL_NOWRITE: assert property (@(posedge clk_i) disable iff (reset_i)
        fail |-> !wr.en) else $error("write taken during supply fail");
    AST_START: assert property (@(posedge clk_i) disable iff (reset_i)
        ev.start && !fail |=> state_ff == rtc_pkg::ST_ADDR) else $error("start missed");
    AST_STOP: assert property (@(posedge clk_i) disable iff (reset_i)
        ev.stop |=> state_ff == rtc_pkg::ST_IDLE) else $error("stop missed");
    AST_WRAP: assert property (@(posedge clk_i) disable iff (reset_i)
        wr.en && !fail |=> ptr_ff == $past(wr.addr) + 3'h1)
        else $error("pointer did not advance");
    AST_ACK_LOW: assert property (@(posedge clk_i) disable iff (reset_i)
        state_ff == rtc_pkg::ST_WRITE_ACK |-> !sda_oe_n_o) else $error("no ack");
    AST_IDLE_REL: assert property (@(posedge clk_i) disable iff (reset_i)
        state_ff == rtc_pkg::ST_IDLE |-> sda_oe_n_o) else $error("idle drive");
    AST_NO_ADDR_ACK: assert property (@(posedge clk_i) disable iff (reset_i)
        state_ff == rtc_pkg::ST_ADDR && ev.scl_fall && bit_ff == 4'h8 && !ev.start
        && !fail && shift_ff[7:1] != `SLAVE_ADDRESS |=> state_ff == rtc_pkg::ST_IDLE)
        else $error("foreign address answered");
    AST_ADDR_ACK_LOW: assert property (@(posedge clk_i) disable iff (reset_i)
        state_ff == rtc_pkg::ST_ADDR_ACK |-> !sda_oe_n_o) else $error("no address ack");
    AST_READ_ACK_REL: assert property (@(posedge clk_i) disable iff (reset_i)
        state_ff == rtc_pkg::ST_READ_ACK |-> sda_oe_n_o)
        else $error("data line held during master ack");

    // A read byte ends by handing the line over, then the master ack or nack decides
    sequence s_read_last_fall;
        state_ff == rtc_pkg::ST_READ && ev.scl_fall && bit_ff == 4'h8 && !fail;
    endsequence
    sequence s_read_nack_fall;
        state_ff == rtc_pkg::ST_READ_ACK && nack_ff && ev.scl_fall;
    endsequence

    AST_READ_PTR: assert property (@(posedge clk_i) disable iff (reset_i)
        s_read_last_fall |=> ptr_ff == $past(ptr_ff) + 3'h1 && sda_oe_n_o)
        else $error("pointer did not advance after read byte");
    AST_NACK_END: assert property (@(posedge clk_i) disable iff (reset_i)
        s_read_nack_fall |=> state_ff == rtc_pkg::ST_IDLE && sda_oe_n_o)
        else $error("read not ended after master nack");

endmodule

`default_nettype wire

// >>> hw/rtc_cfg.svh
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// Register offsets
`define REG_SECONDS 3'h0
`define REG_MINUTES 3'h1
`define REG_CENTURY_HOURS 3'h2
`define REG_WEEKDAY 3'h3
`define REG_DAY_OF_MONTH 3'h4
`define REG_MONTH 3'h5
`define REG_YEAR 3'h6
`define REG_CONTROL 3'h7
`define REG_COUNT 8
`define REG_LAST 3'h7

// Field positions
`define HALT_BIT 7
`define CENTURY_ENABLE_BIT 7
`define CENTURY_FLAG_BIT 6
`define OUT_LEVEL_BIT 7
`define FREQ_TEST_BIT 6
`define CAL_SIGN_BIT 5

// Bus address
`define SLAVE_ADDRESS 7'h68

// Reset values of the time registers
`define RESET_SECONDS 8'h00
`define RESET_MINUTES 8'h00
`define RESET_HOURS 8'h00
`define RESET_WEEKDAY 8'h01
`define RESET_DAY 8'h01
`define RESET_MONTH 8'h01
`define RESET_YEAR 8'h00
`define RESET_CONTROL 8'h80

// Time base: crystal in Hz, one second per this many crystal edges
`define CRYSTAL_HZ 32768
`define CRYSTAL_DIV_W 15

`endif

// >>> hw/rtc_pkg.sv
`default_nettype none

package rtc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WRITE,
        ST_WRITE_ACK,
        ST_READ,
        ST_READ_ACK
    } bus_state_t;

    // One register write from the bus side
    typedef struct packed {
        logic       en;
        logic [2:0] addr;
        logic [7:0] data;
    } reg_write_t;

    // Filtered bus events
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } bus_event_t;

endpackage

`default_nettype wire

// >>> hw/rtc_regfile.sv
`timescale 1ns/100ps
`default_nettype none
`include "rtc_cfg.svh"

module rtc_regfile (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Bus write and read
    input wire rtc_pkg::reg_write_t wr_i,
    input wire logic [2:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    // Time base
    input wire logic tick_i,
    // Control fields
    output logic [7:0] control_o
);

    logic [7:0] regs_ff [`REG_COUNT];
    logic [7:0] nxt_regs [`REG_COUNT];

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = ({y[4], y[1:0]} == 3'b000) || ({y[4], y[1:0]} == 3'b110);
        case (m)
            8'h02: month_days = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
            default: month_days = 8'h31;
        endcase
    endfunction

    wire logic halted = regs_ff[`REG_SECONDS][`HALT_BIT];
    wire logic [7:0] sec = {1'b0, regs_ff[`REG_SECONDS][6:0]};
    wire logic [7:0] hrs = {2'b00, regs_ff[`REG_CENTURY_HOURS][5:0]};
    wire logic [7:0] hrs_inc = bcd_inc(hrs);
    wire logic [7:0] dim = month_days(regs_ff[`REG_MONTH], regs_ff[`REG_YEAR]);
    wire logic c_sec = tick_i && !halted && sec == 8'h59;
    wire logic c_min = c_sec && regs_ff[`REG_MINUTES][6:0] == 7'h59;
    wire logic c_hr = c_min && hrs == 8'h23;
    wire logic c_day = c_hr && regs_ff[`REG_DAY_OF_MONTH][5:0] == dim[5:0];
    wire logic c_mon = c_day && regs_ff[`REG_MONTH][4:0] == 5'h12;
    wire logic c_yr = c_mon && regs_ff[`REG_YEAR] == 8'h99;

    // BCD counting with carries; a bus write wins the same cycle
    always_comb begin
        for (int i = 0; i < `REG_COUNT; i++) begin
            nxt_regs[i] = regs_ff[i];
        end
        if (tick_i && !halted) begin
            nxt_regs[`REG_SECONDS] = c_sec ? 8'h00 : bcd_inc(sec);
        end
        if (c_sec) begin
            nxt_regs[`REG_MINUTES] = c_min ? 8'h00 : bcd_inc({1'b0, regs_ff[1][6:0]});
        end
        if (c_min) begin
            nxt_regs[`REG_CENTURY_HOURS][5:0] = c_hr ? 6'h00 : hrs_inc[5:0];
        end
        if (c_yr && regs_ff[`REG_CENTURY_HOURS][`CENTURY_ENABLE_BIT]) begin
            nxt_regs[`REG_CENTURY_HOURS][`CENTURY_FLAG_BIT] =
                ~regs_ff[`REG_CENTURY_HOURS][`CENTURY_FLAG_BIT];
        end
        if (c_hr) begin
            nxt_regs[`REG_WEEKDAY] = (regs_ff[3][2:0] == 3'h7) ? 8'h01 :
                {5'h00, regs_ff[3][2:0] + 3'h1};
            nxt_regs[`REG_DAY_OF_MONTH] = c_day ? 8'h01 : bcd_inc({2'b00, regs_ff[4][5:0]});
        end
        if (c_day) begin
            nxt_regs[`REG_MONTH] = c_mon ? 8'h01 : bcd_inc({3'b000, regs_ff[5][4:0]});
        end
        if (c_mon) begin
            nxt_regs[`REG_YEAR] = c_yr ? 8'h00 : bcd_inc(regs_ff[`REG_YEAR]);
        end
        if (wr_i.en) begin
            nxt_regs[wr_i.addr] = wr_i.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            regs_ff[0] <= `RESET_SECONDS;
            regs_ff[1] <= `RESET_MINUTES;
            regs_ff[2] <= `RESET_HOURS;
            regs_ff[3] <= `RESET_WEEKDAY;
            regs_ff[4] <= `RESET_DAY;
            regs_ff[5] <= `RESET_MONTH;
            regs_ff[6] <= `RESET_YEAR;
            regs_ff[7] <= `RESET_CONTROL;
            rd_data_o <= 8'h00;
            control_o <= `RESET_CONTROL;
        end else begin
            regs_ff <= nxt_regs;
            rd_data_o <= regs_ff[rd_addr_i];
            control_o <= nxt_regs[`REG_CONTROL];
        end
    end

endmodule

`default_nettype wire

// >>> bench/bus_master_model.sv
`timescale 1ns/100ps
`default_nettype none

module bus_master_model (
    // Clock
    input wire logic clk_i,
    // Bus lines, a data level of 1 releases the line to its pull-up
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);

    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Entered with the bus idle or the clock low, so raising data is never a stop
    task automatic start_cond();
        tick(4);
        sda_o <= 1'b1;
        tick(4);
        scl_o <= 1'b1;
        tick(8);
        sda_o <= 1'b0;
        tick(8);
        scl_o <= 1'b0;
    endtask

    task automatic stop_cond();
        tick(4);
        sda_o <= 1'b0;
        tick(4);
        scl_o <= 1'b1;
        tick(8);
        sda_o <= 1'b1;
        tick(8);
    endtask

    // Eight clocks per bit; data moves mid low phase and is sampled mid high phase
    task automatic bit_x(input logic b, output logic s);
        tick(2);
        sda_o <= b;
        tick(2);
        scl_o <= 1'b1;
        tick(2);
        s = sda_i;
        tick(2);
        scl_o <= 1'b0;
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], s);
        end
        bit_x(1'b1, ack_n);
    endtask

    // Master acknowledges every byte but the last one
    task automatic read_byte(input logic ack_n, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            d[i] = s;
        end
        bit_x(ack_n, s);
    endtask

endmodule

`default_nettype wire

// >>> bench/tb_serial_bus_calendar_clock.sv
`timescale 1ns/100ps
`default_nettype none

module tb_serial_bus_calendar_clock;

    logic clk_i;
    logic reset_i;
    logic crystal;
    logic supply_fail;
    logic scl;
    logic m_sda;
    logic dut_sda;
    logic dut_oe_n;
    logic level_pin;
    logic [7:0] regs [8];
    logic [31:0] rng;
    int ptr;
    int error_cnt;
    int checks;

    // Open-drain data line with pull-up
    wire logic sda_w = m_sda & (dut_oe_n | dut_sda);

    rtc_serial_clock u_rtc_serial_clock (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .scl_i(scl),
        .sda_i(sda_w),
        .sda_o(dut_sda),
        .sda_oe_n_o(dut_oe_n),
        .crystal_input(crystal),
        .supply_fail_i(supply_fail),
        .test_or_level_output_pin(level_pin)
    );

    bus_master_model u_bus_master_model (
        .clk_i(clk_i),
        .sda_i(sda_w),
        .scl_o(scl),
        .sda_o(m_sda)
    );

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // Crystal near 32.768 kHz; a whole second never elapses in this run
    initial begin
        crystal = 1'b0;
        forever begin
            repeat (381) @(posedge clk_i);
            crystal <= ~crystal;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    function automatic logic [7:0] bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction

    // Legal value per register; seconds keep the halt bit set so nothing counts
    function automatic logic [7:0] legal(input int idx);
        logic [31:0] r;
        r = next_rand();
        case (idx)
            0: return 8'h80 | bcd(r % 60);
            1: return bcd(r % 60);
            2: return {r[7:6], 6'h00} | bcd(r % 24);
            3: return bcd(1 + r % 7);
            4: return bcd(1 + r % 28);
            5: return bcd(1 + r % 12);
            6: return bcd(r % 100);
            default: return r[7:0];
        endcase
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic set_ptr(input int p);
        logic a;
        u_bus_master_model.start_cond();
        u_bus_master_model.write_byte(8'hD0, a);
        check({7'h00, a}, 8'h00);
        u_bus_master_model.write_byte(8'(p), a);
        check({7'h00, a}, 8'h00);
        ptr = p;
    endtask

    task automatic write_regs(input int n);
        logic a;
        for (int i = 0; i < n; i++) begin
            regs[ptr] = legal(ptr);
            u_bus_master_model.write_byte(regs[ptr], a);
            check({7'h00, a}, 8'h00);
            ptr = (ptr + 1) % 8;
        end
        u_bus_master_model.stop_cond();
        check({7'h00, level_pin}, {7'h00, regs[7][7]});
    endtask

    task automatic read_regs(input int n);
        logic a;
        logic [7:0] d;
        u_bus_master_model.start_cond();
        u_bus_master_model.write_byte(8'hD1, a);
        check({7'h00, a}, 8'h00);
        for (int i = 0; i < n; i++) begin
            u_bus_master_model.read_byte(i == n - 1, d);
            check(d, regs[ptr]);
            ptr = (ptr + 1) % 8;
        end
        u_bus_master_model.stop_cond();
    endtask

    task automatic foreign_addr(input logic [7:0] addr);
        logic a;
        u_bus_master_model.start_cond();
        u_bus_master_model.write_byte(addr, a);
        check({7'h00, a}, 8'h01);
        u_bus_master_model.write_byte(8'h00, a);
        check({7'h00, a}, 8'h01);
        u_bus_master_model.stop_cond();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic a;
        reset_i = 1'b1;
        supply_fail = 1'b0;
        rng = 32'h0000_0031;
        error_cnt = 0;
        checks = 0;
        ptr = 0;
        regs = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h80};
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        read_regs(8);
        set_ptr(0);
        write_regs(8);
        set_ptr(6);
        write_regs(10);
        set_ptr(0);
        read_regs(16);
        set_ptr(4);
        write_regs(0);
        read_regs(1);
        read_regs(1);
        // Repeated start straight into a read
        set_ptr(2);
        read_regs(3);
        foreign_addr(8'hA0);
        foreign_addr(8'hD2);
        foreign_addr(8'h50);
        read_regs(1);
        // Supply fails in the middle of a write
        set_ptr(3);
        supply_fail <= 1'b1;
        repeat (10) @(posedge clk_i);
        u_bus_master_model.write_byte(8'h55, a);
        check({7'h00, a}, 8'h01);
        u_bus_master_model.stop_cond();
        supply_fail <= 1'b0;
        repeat (10) @(posedge clk_i);
        ptr = 0;
        read_regs(4);
        complete_run();
    end

    initial begin
        repeat (60000) @(posedge clk_i);
        error_cnt++;
        complete_run();
    end

endmodule

`default_nettype wire
